// >>> shared/chrg_defs.svh
`ifndef CHRG_DEFS_SVH
`define CHRG_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CHRG_REG_VOLT_ADAPT 8'h00
`define CHRG_REG_STAT_EOC 8'h01
`define CHRG_REG_USB 8'h02

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CHRG_VSEL_BIT 4
`define CHRG_EOCIND_BIT 4
`define CHRG_CHGIND_BIT 3
`define CHRG_CODE_MSB 3
`define CHRG_EOCSEL_MSB 2
`define CHRG_EOCSEL_LSB 1

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define CHRG_VSEL_DEF 1'b0
`define CHRG_CODE_DEF 4'h8
`define CHRG_EOCSEL_DEF 2'h1
`define CHRG_CODE_MIN 4'h0
`define CHRG_CODE_MAX 4'hd
`define CHRG_EOCSEL_015C 2'h2
`define CHRG_EOCSEL_02C 2'h3

// ----------------------------------------
// Decoded values, mA and thousandths of C
// ----------------------------------------
`define CHRG_CUR_BASE_MA 10'h064
`define CHRG_CUR_STEP_MA 10'h032
`define CHRG_EOC_01C 8'h64
`define CHRG_EOC_015C 8'h96
`define CHRG_EOC_02C 8'hc8

// ----------------------------------------
// Bus bit values
// ----------------------------------------
`define CHRG_DIR_READ 1'b1
`define CHRG_ACK 1'b0
`define CHRG_LAST_BIT 3'h7
`define CHRG_FIRST_TX 3'h1

`endif

// >>> shared/chrg_pkg.sv
package chrg_pkg;
    typedef logic [3:0] chrg_code_type;
    typedef logic [7:0] chrg_byte_type;
    typedef enum logic [3:0] {
        st_idle,
        st_addr,
        st_addr_ack,
        st_reg,
        st_reg_ack,
        st_wdata,
        st_wdata_ack,
        st_rdata,
        st_rdata_ack
    } chrg_link_state_type;
endpackage : chrg_pkg

// >>> rtl/chrg_link.sv
`timescale 1ns/1ps
`include "chrg_defs.svh"

module chrg_link #(
    parameter logic [6:0] TARGET_ADDR = 7'h2a
) (
    // Link clock and reset from core domain
    input logic scl_clk,
    input logic reset,
    // Data line
    input logic sda_in,
    output logic sda_oe,
    // Write event toward core
    output logic wr_toggle,
    output chrg_pkg::chrg_byte_type wr_addr,
    output chrg_pkg::chrg_byte_type wr_data,
    // Register images from core
    input chrg_pkg::chrg_byte_type rd_img0,
    input chrg_pkg::chrg_byte_type rd_img1,
    input chrg_pkg::chrg_byte_type rd_img2
);
    import chrg_pkg::*;

    // ----------------------------------------
    // Synchronisers and bit sampling
    // ----------------------------------------
    logic rst_meta_r, rst_sync_r, sda_hi_r;
    chrg_byte_type img_meta_r [3];
    chrg_byte_type img_sync_r [3];

    always_ff @(negedge scl_clk) begin
        rst_meta_r <= reset;
        rst_sync_r <= rst_meta_r;
        img_meta_r <= '{rd_img0, rd_img1, rd_img2};
        img_sync_r <= img_meta_r;
    end

    always_ff @(posedge scl_clk) begin
        sda_hi_r <= sda_in;
    end

    // ----------------------------------------
    // Protocol engine, falling edge
    // ----------------------------------------
    chrg_link_state_type state_r, state_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    chrg_byte_type shift_r, shift_nxt, ptr_r, ptr_nxt, tx_r, tx_nxt;
    chrg_byte_type waddr_r, waddr_nxt, wdata_r, wdata_nxt, shifted, rd_byte;
    logic rw_r, rw_nxt, oe_r, oe_nxt, wtog_r, wtog_nxt, start;

    always_comb begin
        case (ptr_r)
            `CHRG_REG_VOLT_ADAPT: rd_byte = img_sync_r[0];
            `CHRG_REG_STAT_EOC: rd_byte = img_sync_r[1];
            `CHRG_REG_USB: rd_byte = img_sync_r[2];
            default: rd_byte = '0;
        endcase
    end

    always_comb begin
        start = sda_hi_r & ~sda_in;
        shifted = {shift_r[6:0], sda_hi_r};
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        ptr_nxt = ptr_r;
        tx_nxt = tx_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        rw_nxt = rw_r;
        oe_nxt = 1'b0;
        wtog_nxt = wtog_r;
        if (start) begin
            state_nxt = st_addr;
            cnt_nxt = '0;
        end else begin
            case (state_r)
                st_addr, st_reg, st_wdata: begin
                    shift_nxt = shifted;
                    cnt_nxt = cnt_r + 3'h1;
                    if (cnt_r == `CHRG_LAST_BIT) begin
                        oe_nxt = 1'b1; // see [RULE_08]
                        state_nxt = chrg_link_state_type'(state_r + 4'h1);
                        if (state_r == st_addr) begin
                            rw_nxt = shifted[0]; // see [RULE_08]
                            if (shifted[7:1] != TARGET_ADDR) begin
                                oe_nxt = 1'b0;
                                state_nxt = st_idle;
                            end
                        end else if (state_r == st_reg) begin
                            ptr_nxt = shifted;
                        end else begin
                            waddr_nxt = ptr_r;
                            wdata_nxt = shifted;
                            wtog_nxt = ~wtog_r;
                        end
                    end
                end
                st_addr_ack, st_rdata_ack: begin
                    if (state_r == st_addr_ack && rw_r != `CHRG_DIR_READ) begin
                        state_nxt = st_reg;
                        cnt_nxt = '0;
                    end else if (state_r == st_rdata_ack && sda_hi_r != `CHRG_ACK) begin
                        state_nxt = st_idle;
                    end else begin
                        // Same register again, no auto-increment; see [RULE_11]
                        tx_nxt = rd_byte;
                        oe_nxt = ~rd_byte[7];
                        cnt_nxt = `CHRG_FIRST_TX;
                        state_nxt = st_rdata;
                    end
                end
                st_reg_ack, st_wdata_ack: begin
                    state_nxt = st_wdata;
                    cnt_nxt = '0;
                end
                st_rdata: begin
                    if (cnt_r == '0) begin
                        state_nxt = st_rdata_ack;
                    end else begin
                        oe_nxt = ~tx_r[`CHRG_LAST_BIT - cnt_r];
                        cnt_nxt = cnt_r + 3'h1;
                    end
                end
                default: state_nxt = st_idle;
            endcase
        end
    end

    always_ff @(negedge scl_clk) begin
        if (rst_sync_r) begin
            state_r <= st_idle;
            cnt_r <= '0;
            shift_r <= '0;
            ptr_r <= '0;
            tx_r <= '0;
            waddr_r <= '0;
            wdata_r <= '0;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
            wtog_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            ptr_r <= ptr_nxt;
            tx_r <= tx_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            rw_r <= rw_nxt;
            oe_r <= oe_nxt;
            wtog_r <= wtog_nxt;
        end
    end

    assign sda_oe = oe_r;
    assign wr_toggle = wtog_r;
    assign wr_addr = waddr_r;
    assign wr_data = wdata_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_addr_ack: assert property (@(negedge scl_clk) disable iff (rst_sync_r) // see [RULE_08]
        !start && state_r == st_addr && cnt_r == `CHRG_LAST_BIT
        && shifted[7:1] == TARGET_ADDR |=> oe_r ##1 (state_r != st_addr_ack || !oe_r
        || rw_r == `CHRG_DIR_READ))
        else $error("address not acknowledged by pulling data low");
    chk_host_ack_read: assert property (@(negedge scl_clk) disable iff (rst_sync_r) // see [RULE_08]
        !start && state_r == st_rdata_ack && sda_hi_r != `CHRG_ACK |=> state_r == st_idle)
        else $error("read continued after host gave no acknowledge");
endmodule : chrg_link

// >>> rtl/chrg_regbank.sv
`timescale 1ns/1ps
`include "chrg_defs.svh"

// Contract
// [RULE_01] Power-up loads every programmable field with its default value.
// [RULE_02] Written contents stay while battery is above 2.85 V.
// [RULE_03] 8'h00 holds voltage select bit 4, adaptor code 3:0; 8'h02 USB code.
// [RULE_04] Defaults: voltage select 0, both codes 1000, end select 01.
// [RULE_05] 8'h01 bits 4 and 3 read-only status; other fields read/write.
// [RULE_06] Current is 100 mA plus 50 mA per code step, 750 max.
// [RULE_07] End select codes 1, 2, 3 give 0.1C, 0.15C, 0.2C.
// [RULE_08] Direction bit 0 writes, 1 reads; receiver acknowledges by pulling low.
// [RULE_09] USB mode uses USB code only with select pin low, else 100 mA.
// [RULE_10] Status bits mirror the charging and end-of-charge indicator states.
// [RULE_11] Host reads via address write, repeated start, read; no auto-increment.
// [RULE_12] Host avoids current codes 4'he, 4'hf and end select code 0.

module chrg_regbank #(
    parameter logic [6:0] TARGET_ADDR = 7'h2a
) (
    // Core clock and reset
    input logic clk,
    input logic reset,
    // Link
    input logic scl_clk,
    input logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Charger pins and status
    input logic battery_ok,
    input logic usb_mode,
    input logic current_select_pin,
    input logic charging_indicator,
    input logic eoc_indicator,
    // Settings toward the charger core
    output logic batt_voltage_sel,
    output chrg_pkg::chrg_code_type charge_code,
    output logic [9:0] charge_ma,
    output logic [7:0] eoc_milli_c
);
    import chrg_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] pin_meta_r;
    logic [4:0] pin_sync_r;
    logic batt_s;
    logic usb_s;
    logic current_select_pin_s;
    logic chg_s;
    logic eoc_s;

    always_ff @(posedge clk) begin
        pin_meta_r <= {battery_ok, usb_mode, current_select_pin,
                       charging_indicator, eoc_indicator};
        pin_sync_r <= pin_meta_r;
    end

    assign {batt_s, usb_s, current_select_pin_s, chg_s, eoc_s} = pin_sync_r;

    // ----------------------------------------
    // Link instance
    // ----------------------------------------
    logic link_oe;
    logic link_tog;
    chrg_byte_type link_addr;
    chrg_byte_type link_data;
    chrg_byte_type img0_r, img0_nxt;
    chrg_byte_type img1_r, img1_nxt;
    chrg_byte_type img2_r, img2_nxt;

    chrg_link #(
        .TARGET_ADDR(TARGET_ADDR)
    ) u_link (
        .scl_clk(scl_clk),
        .reset(reset),
        .sda_in(sda_in),
        .sda_oe(link_oe),
        .wr_toggle(link_tog),
        .wr_addr(link_addr),
        .wr_data(link_data),
        .rd_img0(img0_r),
        .rd_img1(img1_r),
        .rd_img2(img2_r)
    );

    assign sda_oe = link_oe;

    // ----------------------------------------
    // Write event crossing
    // ----------------------------------------
    logic tog_meta_r;
    logic tog_sync_r;
    logic tog_seen_r;
    logic wr_evt;

    always_ff @(posedge clk) begin
        tog_meta_r <= link_tog;
        tog_sync_r <= tog_meta_r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tog_seen_r <= 1'b0;
        end else begin
            tog_seen_r <= tog_sync_r;
        end
    end

    // Address and data stay put for a whole byte after the toggle
    assign wr_evt = tog_sync_r ^ tog_seen_r;

    // ----------------------------------------
    // Programmable fields
    // ----------------------------------------
    logic vsel_r, vsel_nxt;
    chrg_code_type ac_code_r, ac_code_nxt;
    chrg_code_type usb_code_r, usb_code_nxt;
    logic [1:0] eoc_sel_r, eoc_sel_nxt;

    always_comb begin
        vsel_nxt = vsel_r;
        ac_code_nxt = ac_code_r;
        usb_code_nxt = usb_code_r;
        eoc_sel_nxt = eoc_sel_r;
        if (!batt_s) begin
            // Contents lost below the retention voltage
            vsel_nxt = `CHRG_VSEL_DEF; // see [RULE_02]
            ac_code_nxt = `CHRG_CODE_DEF; // see [RULE_04]
            usb_code_nxt = `CHRG_CODE_DEF;
            eoc_sel_nxt = `CHRG_EOCSEL_DEF;
        end else if (wr_evt) begin
            case (link_addr)
                `CHRG_REG_VOLT_ADAPT: begin
                    vsel_nxt = link_data[`CHRG_VSEL_BIT]; // see [RULE_03]
                    ac_code_nxt = link_data[`CHRG_CODE_MSB:0];
                end
                `CHRG_REG_STAT_EOC: begin
                    // Status bits are not stored; see [RULE_05]
                    eoc_sel_nxt = link_data[`CHRG_EOCSEL_MSB:`CHRG_EOCSEL_LSB];
                end
                `CHRG_REG_USB: begin
                    usb_code_nxt = link_data[`CHRG_CODE_MSB:0]; // see [RULE_03]
                end
                default: begin
                    vsel_nxt = vsel_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            vsel_r <= `CHRG_VSEL_DEF; // see [RULE_01]
            ac_code_r <= `CHRG_CODE_DEF; // see [RULE_04]
            usb_code_r <= `CHRG_CODE_DEF;
            eoc_sel_r <= `CHRG_EOCSEL_DEF;
        end else begin
            vsel_r <= vsel_nxt;
            ac_code_r <= ac_code_nxt;
            usb_code_r <= usb_code_nxt;
            eoc_sel_r <= eoc_sel_nxt;
        end
    end

    // ----------------------------------------
    // Read images for the link
    // ----------------------------------------
    always_comb begin
        img0_nxt = '0;
        img0_nxt[`CHRG_VSEL_BIT] = vsel_r;
        img0_nxt[`CHRG_CODE_MSB:0] = ac_code_r;
        img1_nxt = '0;
        img1_nxt[`CHRG_EOCIND_BIT] = eoc_s; // see [RULE_10]
        img1_nxt[`CHRG_CHGIND_BIT] = chg_s;
        img1_nxt[`CHRG_EOCSEL_MSB:`CHRG_EOCSEL_LSB] = eoc_sel_r;
        img2_nxt = '0;
        img2_nxt[`CHRG_CODE_MSB:0] = usb_code_r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            img0_r <= '0;
            img1_r <= '0;
            img2_r <= '0;
        end else begin
            img0_r <= img0_nxt;
            img1_r <= img1_nxt;
            img2_r <= img2_nxt;
        end
    end

    // ----------------------------------------
    // Decoded settings
    // ----------------------------------------
    logic vout_r, vout_nxt;
    chrg_code_type code_r, code_nxt;
    logic [9:0] ma_r, ma_nxt;
    logic [7:0] eoc_r, eoc_nxt;
    logic sda_out_r;

    always_comb begin
        vout_nxt = vsel_r;
        if (!usb_s) begin
            code_nxt = ac_code_r;
        end else if (current_select_pin_s) begin
            code_nxt = `CHRG_CODE_MIN; // see [RULE_09]
        end else begin
            code_nxt = usb_code_r;
        end
        if (code_nxt > `CHRG_CODE_MAX) begin
            code_nxt = `CHRG_CODE_MAX; // see [RULE_12]
        end
        ma_nxt = `CHRG_CUR_BASE_MA + 10'(code_nxt) * `CHRG_CUR_STEP_MA; // see [RULE_06]
        case (eoc_sel_r)
            `CHRG_EOCSEL_015C: eoc_nxt = `CHRG_EOC_015C; // see [RULE_07]
            `CHRG_EOCSEL_02C: eoc_nxt = `CHRG_EOC_02C;
            default: eoc_nxt = `CHRG_EOC_01C;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            vout_r <= `CHRG_VSEL_DEF;
            code_r <= `CHRG_CODE_MIN;
            ma_r <= `CHRG_CUR_BASE_MA;
            eoc_r <= `CHRG_EOC_01C;
            sda_out_r <= 1'b0;
        end else begin
            vout_r <= vout_nxt;
            code_r <= code_nxt;
            ma_r <= ma_nxt;
            eoc_r <= eoc_nxt;
            // Open drain: only the enable ever moves
            sda_out_r <= 1'b0; // see [RULE_08]
        end
    end

    assign batt_voltage_sel = vout_r;
    assign charge_code = code_r;
    assign charge_ma = ma_r;
    assign eoc_milli_c = eoc_r;
    assign sda_out = sda_out_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_powerup_defaults: assert property (@(posedge clk) // see [RULE_01]
        $fell(reset) |-> vsel_r == `CHRG_VSEL_DEF && ac_code_r == `CHRG_CODE_DEF
        && usb_code_r == `CHRG_CODE_DEF && eoc_sel_r == `CHRG_EOCSEL_DEF)
        else $error("fields not at defaults after reset");

    chk_fields_retained: assert property (@(posedge clk) disable iff (reset) // see [RULE_02]
        batt_s && !wr_evt |=> $stable({vsel_r, ac_code_r, usb_code_r, eoc_sel_r}))
        else $error("field changed without a write");

    chk_low_batt_reload: assert property (@(posedge clk) disable iff (reset) // see [RULE_02]
        !batt_s |=> ac_code_r == `CHRG_CODE_DEF && eoc_sel_r == `CHRG_EOCSEL_DEF)
        else $error("defaults not reloaded on low battery");

    chk_write_reg0: assert property (@(posedge clk) disable iff (reset) // see [RULE_03]
        batt_s && wr_evt && link_addr == `CHRG_REG_VOLT_ADAPT
        |=> vsel_r == $past(link_data[`CHRG_VSEL_BIT])
        && ac_code_r == $past(link_data[`CHRG_CODE_MSB:0]) ##1 img0_r[`CHRG_VSEL_BIT] == vsel_r)
        else $error("write to voltage and adaptor register lost");

    chk_write_usb: assert property (@(posedge clk) disable iff (reset) // see [RULE_03]
        batt_s && wr_evt && link_addr == `CHRG_REG_USB
        |=> usb_code_r == $past(link_data[`CHRG_CODE_MSB:0]))
        else $error("write to usb current register lost");

    chk_eoc_sel_write: assert property (@(posedge clk) disable iff (reset) // see [RULE_05]
        batt_s && wr_evt && link_addr == `CHRG_REG_STAT_EOC
        |=> eoc_sel_r == $past(link_data[`CHRG_EOCSEL_MSB:`CHRG_EOCSEL_LSB]))
        else $error("end select write lost");

    chk_status_mirror: assert property (@(posedge clk) disable iff (reset) // see [RULE_10]
        1'b1 |=> img1_r[`CHRG_EOCIND_BIT] == $past(eoc_s)
        && img1_r[`CHRG_CHGIND_BIT] == $past(chg_s))
        else $error("status bits do not follow indicators");

    chk_current_map: assert property (@(posedge clk) disable iff (reset) // see [RULE_06]
        charge_ma == `CHRG_CUR_BASE_MA + 10'(charge_code) * `CHRG_CUR_STEP_MA
        && charge_code <= `CHRG_CODE_MAX)
        else $error("current does not match code");

    chk_eoc_decode: assert property (@(posedge clk) disable iff (reset) // see [RULE_07]
        eoc_sel_r == `CHRG_EOCSEL_015C |=> eoc_milli_c == `CHRG_EOC_015C)
        else $error("end threshold decode wrong");

    chk_usb_current_select_pin_high: assert property (@(posedge clk) disable iff (reset) // see [RULE_09]
        usb_s && current_select_pin_s |=> charge_code == `CHRG_CODE_MIN && charge_ma == `CHRG_CUR_BASE_MA)
        else $error("usb mode with select high not at 100 mA");

    chk_usb_current_select_pin_low: assert property (@(posedge clk) disable iff (reset) // see [RULE_09]
        usb_s && !current_select_pin_s && usb_code_r <= `CHRG_CODE_MAX |=> charge_code == $past(usb_code_r))
        else $error("usb code not applied with select low");

    chk_adaptor_code: assert property (@(posedge clk) disable iff (reset) // see [RULE_03]
        !usb_s && ac_code_r <= `CHRG_CODE_MAX |=> charge_code == $past(ac_code_r))
        else $error("adaptor code not applied");

    chk_eoc_decode_lo: assert property (@(posedge clk) disable iff (reset) // see [RULE_07]
        eoc_sel_r == `CHRG_EOCSEL_DEF |=> eoc_milli_c == `CHRG_EOC_01C)
        else $error("low end threshold decode wrong");

    chk_eoc_decode_hi: assert property (@(posedge clk) disable iff (reset) // see [RULE_07]
        eoc_sel_r == `CHRG_EOCSEL_02C |=> eoc_milli_c == `CHRG_EOC_02C)
        else $error("high end threshold decode wrong");
endmodule : chrg_regbank

// >>> tb/chrg_host_model.sv
`timescale 1ns/1ps

module chrg_host_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    // Bus lines
    output logic scl,
    output logic host_pull,
    input wire logic sda_wire
);
    initial begin
        scl = 1'b1;
        host_pull = 1'b0;
    end

    // ----------------------------------------
    // Bit level, SCL low then high, 48 ns
    // ----------------------------------------
    task automatic bit_io(input logic b, output logic seen);
        #12 host_pull = ~b;
        #12 scl = 1'b1;
        #12 seen = sda_wire;
        #12 scl = 1'b0;
    endtask : bit_io

    task automatic start_cond();
        // Link only sees START after a rise with SDA high
        #12 scl = 1'b0;
        #12 host_pull = 1'b0;
        #12 scl = 1'b1;
        #12 host_pull = 1'b1;
        #12 scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        #12 host_pull = 1'b1;
        #12 scl = 1'b1;
        #12 host_pull = 1'b0;
    endtask : stop_cond

    task automatic clocks(input int n);
        repeat (n) begin
            #24 scl = 1'b0;
            #24 scl = 1'b1;
        end
    endtask : clocks

    // ----------------------------------------
    // Byte level and transfers
    // ----------------------------------------
    task automatic byte_out(input logic [7:0] d, output logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, nak);
    endtask : byte_out

    task automatic byte_in(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(1'b1, s);
    endtask : byte_in

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d,
            output logic nak);
        logic n0, n1, n2;
        start_cond();
        byte_out({dev, 1'b0}, n0);
        byte_out(r, n1);
        byte_out(d, n2);
        stop_cond();
        nak = n0 | n1 | n2;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] r, output logic [7:0] d, output logic nak);
        logic n0, n1, n2;
        start_cond();
        byte_out({ADDR, 1'b0}, n0);
        byte_out(r, n1);
        start_cond();
        byte_out({ADDR, 1'b1}, n2);
        byte_in(d);
        stop_cond();
        nak = n0 | n1 | n2;
    endtask : read_reg
endmodule : chrg_host_model

// >>> tb/chrg_regbank_tb_top.sv
`timescale 1ns/1ps

module chrg_regbank_tb_top;
    import chrg_pkg::*;
    localparam logic [6:0] ADDR = 7'h2a;
    localparam int LIMIT = 20000;
    logic clk, reset, scl, host_pull, sda_wire, sda_out, sda_oe;
    logic battery_ok, usb_mode, current_select_pin, charging_indicator, eoc_indicator;
    logic batt_voltage_sel;
    chrg_code_type charge_code;
    logic [9:0] charge_ma;
    logic [7:0] eoc_milli_c;
    int errors, checks_done, cycles;

    // Pull-up on the data line
    assign sda_wire = ~host_pull & (sda_out | ~sda_oe);

    chrg_regbank #(.TARGET_ADDR(ADDR)) chrg_regbank_i (
        .clk(clk), .reset(reset), .scl_clk(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .battery_ok(battery_ok), .usb_mode(usb_mode),
        .current_select_pin(current_select_pin), .charging_indicator(charging_indicator),
        .eoc_indicator(eoc_indicator), .batt_voltage_sel(batt_voltage_sel),
        .charge_code(charge_code), .charge_ma(charge_ma), .eoc_milli_c(eoc_milli_c)
    );

    chrg_host_model #(.ADDR(ADDR)) chrg_host_model_i (
        .scl(scl), .host_pull(host_pull), .sda_wire(sda_wire)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [22:0] got, input logic [22:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [22:0] ex(input logic v, input logic [3:0] c, input logic [7:0] e);
        return {v, c, 10'h064 + 10'h032 * {6'h00, c}, e};
    endfunction : ex

    task automatic settle();
        repeat (10) @(posedge clk);
    endtask : settle

    task automatic outs(input logic [22:0] exp);
        settle();
        chk({batt_voltage_sel, charge_code, charge_ma, eoc_milli_c}, exp);
    endtask : outs

    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        logic nak;
        chrg_host_model_i.write_reg(ADDR, r, d, nak);
        chk({22'h0, nak}, 23'h0);
    endtask : wr

    task automatic rdchk(input logic [7:0] r, input logic [7:0] exp);
        logic [7:0] d;
        logic nak;
        chrg_host_model_i.read_reg(r, d, nak);
        chk({14'h0, nak, d}, {15'h0, exp});
    endtask : rdchk

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_defaults();
        outs(ex(1'b0, 4'h8, 8'h64));
        rdchk(8'h00, 8'h08);
        rdchk(8'h01, 8'h02);
        rdchk(8'h02, 8'h08);
    endtask : t_defaults

    task automatic t_adaptor();
        logic [7:0] vals[3] = '{8'h13, 8'hfd, 8'h00};
        foreach (vals[i]) begin
            wr(8'h00, vals[i]);
            rdchk(8'h00, vals[i] & 8'h1f);
            outs(ex(vals[i][4], vals[i][3:0], 8'h64));
        end
    endtask : t_adaptor

    task automatic t_eoc();
        logic [7:0] tbl[4] = '{8'h00, 8'h64, 8'h96, 8'hc8};
        for (int c = 1; c < 4; c++) begin
            wr(8'h01, {5'h1f, c[1:0], 1'b1});
            rdchk(8'h01, {5'h00, c[1:0], 1'b0});
            settle();
            chk({15'h0, eoc_milli_c}, {15'h0, tbl[c]});
        end
    endtask : t_eoc

    task automatic t_status();
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            charging_indicator <= k[1];
            eoc_indicator <= k[0];
            settle();
            rdchk(8'h01, {3'h0, k[0], k[1], 3'h6});
        end
        @(posedge clk);
        charging_indicator <= 1'b0;
        eoc_indicator <= 1'b0;
    endtask : t_status

    task automatic t_usb();
        wr(8'h00, 8'h0a);
        @(posedge clk);
        usb_mode <= 1'b1;
        wr(8'h02, 8'h05);
        outs(ex(1'b0, 4'h5, 8'hc8));
        current_select_pin <= 1'b1;
        outs(ex(1'b0, 4'h0, 8'hc8));
        usb_mode <= 1'b0;
        outs(ex(1'b0, 4'ha, 8'hc8));
        current_select_pin <= 1'b0;
    endtask : t_usb

    task automatic t_retention();
        repeat (200) @(posedge clk);
        rdchk(8'h02, 8'h05);
        @(posedge clk);
        battery_ok <= 1'b0;
        outs(ex(1'b0, 4'h8, 8'h64));
        battery_ok <= 1'b1;
        rdchk(8'h00, 8'h08);
        rdchk(8'h01, 8'h02);
        rdchk(8'h02, 8'h08);
    endtask : t_retention

    task automatic t_bad_addr();
        logic nak;
        chrg_host_model_i.write_reg(ADDR ^ 7'h01, 8'h00, 8'h1f, nak);
        chk({22'h0, nak}, 23'h1);
        rdchk(8'h00, 8'h08);
        rdchk(8'h05, 8'h00);
    endtask : t_bad_addr

    // ----------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------
    task automatic close_out();
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            close_out();
        end
    end

    initial begin
        cycles = 0;
        errors = 0;
        checks_done = 0;
        reset = 1'b1;
        battery_ok = 1'b1;
        usb_mode = 1'b0;
        current_select_pin = 1'b0;
        charging_indicator = 1'b0;
        eoc_indicator = 1'b0;
        // Link reset crosses on SCL falls, so SCL runs through the release
        fork
            chrg_host_model_i.clocks(6);
            begin
                repeat (12) @(posedge clk);
                reset <= 1'b0;
            end
        join
        t_defaults();
        t_adaptor();
        t_eoc();
        t_status();
        t_usb();
        t_retention();
        t_bad_addr();
        close_out();
    end
endmodule : chrg_regbank_tb_top
